// ==== verilog/iepu_top.sv ====
/*
 * Interrupt enable, priority and context-save unit: APB registers, pin
 * edge capture, timer0 rollover, port change, requests to the core.
 * Assumes core and peripheral signals run on pclk; pins are asynchronous.
 */
// Overview of operation
// - Enable two: bits 7-4 zero, 3-0 clear
// - Priority one bits 6-0 writable, reset high
// - Priority two: bits 7-4 zero, reset high
// - External pins edge triggered, edge selectable
// - Valid edge sets flag; enable gates request
// - Enabled external edge wakes sleeping core
// - Vector after wake only with global enable
// - External one and two priority bits
// - External zero always high priority
// - Timer0 8-bit rollover sets flag
// - Timer0 16-bit rollover sets flag
// - Timer0 enable and priority bits
// - Port B 7:4 change sets flag
// - Port change enable and priority bits
// - Interrupt entry pushes return address
// - Interrupt entry saves working, status, bank
// - Flags set regardless of enables
// - Compatibility mode needs peripheral enable
// - Priority bits act only in priority mode
`timescale 1ns/1ns

module iepu_top
    import iepu_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_irq_zero,
    input  wire logic        ext_irq_one,
    input  wire logic        ext_irq_two,
    input  wire logic [7:4]  port_b_pins,
    input  wire logic [6:0]  periph_flags_one,
    input  wire logic [3:0]  periph_flags_two,
    input  wire logic        core_sleep,
    input  wire logic        core_irq_ack,
    input  wire logic        core_ret_pop,
    input  wire iepu_pc_t    core_return_pc,
    input  wire iepu_ctx_s   core_ctx,
    output logic             irq_high_q,
    output logic             irq_low_q,
    output logic             wake_q,
    output iepu_ctx_s        fast_ctx_q,
    output iepu_pc_t         stack_top_q,
    output logic [4:0]       stack_depth_q
);

    logic [7:0]  main_ctl_q;
    logic [6:4]  edge_sel_q;
    logic        t0_prio_q;
    logic        rb_prio_q;
    logic [1:0]  ext_prio_q;
    logic [1:0]  ext_en_q;
    logic [1:0]  ext_flag_q;
    logic [6:0]  periph_en1_q;
    logic [3:0]  periph_en2_q;
    logic [6:0]  periph_pr1_q;
    logic [3:0]  periph_pr2_q;
    logic        prio_mode_q;
    logic        t0_run_q;
    iepu_t0_mode_e t0_mode_q;
    logic [15:0] t0_count_q;
    logic [7:4]  rb_latch_q;
    logic [2:0]  ext_prev_q;
    logic [31:0] rd_d;
    logic        hit_d;

    logic [2:0]  ext_lvl;
    logic [7:4]  rb_lvl;
    logic        setup;
    logic        acc;
    logic        wr;
    logic [2:0]  ext_hit;
    logic        t0_roll;
    logic        t0_hold;
    logic        rb_mismatch;
    logic [15:0] src_flag;
    logic [15:0] src_en;
    logic [15:0] src_prio;
    logic [15:0] src_periph;
    logic [15:0] pending;
    logic        want_high;
    logic        want_low;

    iepu_sync #(.W(7)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  ({port_b_pins, ext_irq_two, ext_irq_one, ext_irq_zero}),
        .level_q ({rb_lvl, ext_lvl})
    );

    assign setup = psel && !penable;
    assign acc   = psel && penable;
    assign wr    = acc && pwrite;

    for (genvar i = 0; i < 3; i++) begin : g_edge
        assign ext_hit[i] = edge_sel_q[4+i] ? (ext_lvl[i] && !ext_prev_q[i])
                                            : (!ext_lvl[i] && ext_prev_q[i]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_q <= 3'h0;
        end else begin
            ext_prev_q <= ext_lvl;
        end
    end

    // Rollover per mode
    // Counter writes pre-empt the increment, so no rollover then
    assign t0_hold = wr && (paddr == `IEPU_OFF_TMR0_CTL || paddr == `IEPU_OFF_TMR0_COUNT);
    assign t0_roll = t0_run_q && !t0_hold && ((t0_mode_q == IEPU_T0_8BIT)
                     ? (t0_count_q[7:0] == `IEPU_T0_LOW_MAX)
                     : (t0_count_q == `IEPU_T0_FULL_MAX));

    assign rb_mismatch = (rb_lvl != rb_latch_q);

    // Flags set regardless of enables; set beats a clearing write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_ctl_q <= 8'h00;
        end else begin
            if (wr && paddr == `IEPU_OFF_MAIN_CTL) begin
                main_ctl_q <= pwdata[7:0];
            end
            if (ext_hit[0]) begin
                main_ctl_q[`IEPU_MAIN_X0_FLAG] <= 1'b1;
            end
            if (t0_roll) begin
                main_ctl_q[`IEPU_MAIN_T0_FLAG] <= 1'b1;
            end
            if (rb_mismatch) begin
                main_ctl_q[`IEPU_MAIN_RB_FLAG] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_sel_q <= `IEPU_RST_EDGE;
            t0_prio_q  <= 1'b1;
            rb_prio_q  <= 1'b1;
            ext_prio_q <= 2'h3;
            ext_en_q   <= 2'h0;
        end else if (wr && paddr == `IEPU_OFF_SECOND_CTL) begin
            edge_sel_q <= pwdata[6:4];
            t0_prio_q  <= pwdata[`IEPU_SEC_T0_PRIO];
            rb_prio_q  <= pwdata[`IEPU_SEC_RB_PRIO];
        end else if (wr && paddr == `IEPU_OFF_THIRD_CTL) begin
            ext_prio_q <= {pwdata[`IEPU_THR_X2_PRIO], pwdata[`IEPU_THR_X1_PRIO]};
            ext_en_q   <= {pwdata[`IEPU_THR_X2_EN], pwdata[`IEPU_THR_X1_EN]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_flag_q <= 2'h0;
        end else begin
            if (wr && paddr == `IEPU_OFF_THIRD_CTL) begin
                ext_flag_q <= {pwdata[`IEPU_THR_X2_FLAG], pwdata[`IEPU_THR_X1_FLAG]};
            end
            if (ext_hit[1]) begin
                ext_flag_q[0] <= 1'b1;
            end
            if (ext_hit[2]) begin
                ext_flag_q[1] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_en1_q <= 7'h00;
            periph_en2_q <= `IEPU_RST_EN2;
            periph_pr1_q <= `IEPU_RST_PR1;
            periph_pr2_q <= `IEPU_RST_PR2;
            prio_mode_q  <= 1'b0;
        end else if (wr) begin
            unique case (paddr)
                `IEPU_OFF_PERIPH_EN1: periph_en1_q <= pwdata[6:0];
                `IEPU_OFF_PERIPH_EN2: periph_en2_q <= pwdata[3:0];
                `IEPU_OFF_PERIPH_PR1: periph_pr1_q <= pwdata[6:0];
                `IEPU_OFF_PERIPH_PR2: periph_pr2_q <= pwdata[3:0];
                `IEPU_OFF_PRIO_MODE:  prio_mode_q  <= pwdata[`IEPU_PRIO_MODE_BIT];
                default: ;
            endcase
        end
    end

    // Timer0 counter, wraps in the selected width
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t0_run_q   <= 1'b0;
            t0_mode_q  <= IEPU_T0_8BIT;
            t0_count_q <= 16'h0000;
        end else if (wr && paddr == `IEPU_OFF_TMR0_CTL) begin
            t0_run_q  <= pwdata[`IEPU_T0_RUN_BIT];
            t0_mode_q <= iepu_t0_mode_e'(pwdata[`IEPU_T0_MODE16_BIT]);
        end else if (wr && paddr == `IEPU_OFF_TMR0_COUNT) begin
            t0_count_q <= pwdata[15:0];
        end else if (t0_run_q) begin
            if (t0_mode_q == IEPU_T0_8BIT) begin
                t0_count_q[7:0] <= t0_count_q[7:0] + 8'h01;
            end else begin
                t0_count_q <= t0_count_q + 16'h0001;
            end
        end
    end

    // Any port access ends the mismatch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rb_latch_q <= 4'h0;
        end else if (acc && paddr == `IEPU_OFF_PORT_B) begin
            rb_latch_q <= rb_lvl;
        end
    end

    // Source vectors; external zero fixed high
    assign src_flag = {periph_flags_two, periph_flags_one,
                       main_ctl_q[`IEPU_MAIN_RB_FLAG], main_ctl_q[`IEPU_MAIN_T0_FLAG],
                       ext_flag_q, main_ctl_q[`IEPU_MAIN_X0_FLAG]};
    assign src_en   = {periph_en2_q, periph_en1_q,
                       main_ctl_q[`IEPU_MAIN_RB_EN], main_ctl_q[`IEPU_MAIN_T0_EN],
                       ext_en_q, main_ctl_q[`IEPU_MAIN_X0_EN]};
    assign src_prio = {periph_pr2_q, periph_pr1_q, rb_prio_q, t0_prio_q,
                       ext_prio_q, 1'b1};
    assign src_periph = 16'hFFE0;
    assign pending    = src_flag & src_en;

    always_comb begin
        if (prio_mode_q) begin
            want_high = |(pending & src_prio);
            want_low  = main_ctl_q[`IEPU_MAIN_PERIPHERAL_IRQ_ENABLE] && |(pending & ~src_prio);
        end else begin
            want_high = |(pending & ~src_periph)
                        || (main_ctl_q[`IEPU_MAIN_PERIPHERAL_IRQ_ENABLE] && |(pending & src_periph));
            want_low  = 1'b0;
        end
    end

    // Wake always; vector only with global enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_high_q <= 1'b0;
            irq_low_q  <= 1'b0;
            wake_q     <= 1'b0;
        end else begin
            irq_high_q <= main_ctl_q[`IEPU_MAIN_GIE] && want_high;
            irq_low_q  <= main_ctl_q[`IEPU_MAIN_GIE] && want_low;
            wake_q     <= core_sleep && |pending;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_ctx_q <= '0;
        end else if (core_irq_ack) begin
            fast_ctx_q <= core_ctx;
        end
    end

    iepu_ret_stack u_stack (
        .pclk    (pclk),
        .presetn (presetn),
        .push    (core_irq_ack),
        .pop     (core_ret_pop && !core_irq_ack),
        .push_pc (core_return_pc),
        .top_q   (stack_top_q),
        .depth_q (stack_depth_q)
    );

    // Read mux, unused upper bits zero
    always_comb begin
        rd_d  = 32'h0000_0000;
        hit_d = 1'b1;
        unique case (paddr)
            `IEPU_OFF_MAIN_CTL:   rd_d[7:0] = main_ctl_q;
            `IEPU_OFF_SECOND_CTL: rd_d[7:0] = {1'b0, edge_sel_q, 1'b0, t0_prio_q,
                                               1'b0, rb_prio_q};
            `IEPU_OFF_THIRD_CTL:  rd_d[7:0] = {ext_prio_q[1], ext_prio_q[0], 1'b0,
                                               ext_en_q, 1'b0, ext_flag_q};
            `IEPU_OFF_PERIPH_EN1: rd_d[6:0] = periph_en1_q;
            `IEPU_OFF_PERIPH_EN2: rd_d[3:0] = periph_en2_q;
            `IEPU_OFF_PERIPH_PR1: rd_d[6:0] = periph_pr1_q;
            `IEPU_OFF_PERIPH_PR2: rd_d[3:0] = periph_pr2_q;
            `IEPU_OFF_PRIO_MODE:  rd_d[`IEPU_PRIO_MODE_BIT] = prio_mode_q;
            `IEPU_OFF_TMR0_CTL:   rd_d[1:0] = {t0_run_q, t0_mode_q};
            `IEPU_OFF_TMR0_COUNT: rd_d[15:0] = t0_count_q;
            `IEPU_OFF_PORT_B:     rd_d[7:0] = {rb_lvl, 1'b0, ext_lvl};
            `IEPU_OFF_STATUS:     rd_d[4:0] = {core_sleep, wake_q, irq_low_q,
                                               irq_high_q, rb_mismatch};
            default:              hit_d = 1'b0;
        endcase
    end

    // Read data and error captured in setup, shown in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_d;
                pslverr <= !hit_d;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_x0_rise;
        edge_sel_q[4] && ext_lvl[0] && !ext_prev_q[0];
    endsequence

    property p_en2_upper;
        setup && !pwrite && paddr == `IEPU_OFF_PERIPH_EN2 |=> prdata[7:4] == 4'h0;
    endproperty
    a_en2_upper: assert property (p_en2_upper) else $error("enable two upper bits");

    property p_pr1_write;
        wr && paddr == `IEPU_OFF_PERIPH_PR1 |=> periph_pr1_q == $past(pwdata[6:0]);
    endproperty
    a_pr1_write: assert property (p_pr1_write) else $error("priority one write");

    property p_pr2_upper;
        setup && !pwrite && paddr == `IEPU_OFF_PERIPH_PR2 |=> prdata[31:4] == 28'h0;
    endproperty
    a_pr2_upper: assert property (p_pr2_upper) else $error("priority two upper bits");

    property p_x0_flag;
        s_x0_rise |=> main_ctl_q[`IEPU_MAIN_X0_FLAG];
    endproperty
    a_x0_flag: assert property (p_x0_flag) else $error("edge missed");

    property p_x0_high;
        main_ctl_q[`IEPU_MAIN_X0_FLAG] && main_ctl_q[`IEPU_MAIN_X0_EN]
            && main_ctl_q[`IEPU_MAIN_GIE] && !want_low |=> irq_high_q && !irq_low_q;
    endproperty
    a_x0_high: assert property (p_x0_high) else $error("zero not high");

    property p_t0_roll8;
        t0_run_q && t0_mode_q == IEPU_T0_8BIT && t0_count_q[7:0] == 8'hFF
            && !wr |=> main_ctl_q[`IEPU_MAIN_T0_FLAG] && t0_count_q[7:0] == 8'h00;
    endproperty
    a_t0_roll8: assert property (p_t0_roll8) else $error("timer0 rollover");

    property p_rb_change;
        rb_mismatch |=> main_ctl_q[`IEPU_MAIN_RB_FLAG];
    endproperty
    a_rb_change: assert property (p_rb_change) else $error("port change");

    property p_ctx_save;
        core_irq_ack |=> fast_ctx_q == $past(core_ctx) && stack_depth_q != 5'h00;
    endproperty
    a_ctx_save: assert property (p_ctx_save) else $error("context save");

    property p_no_low_compat;
        !prio_mode_q |=> !irq_low_q;
    endproperty
    a_no_low_compat: assert property (p_no_low_compat) else $error("low in compat");

endmodule : iepu_top

// ==== verilog/iepu_cfg.svh ====
/*
 * Offsets, field positions, reset values and sizes of the interrupt
 * enable and priority unit. Definitions only; included by bare name.
 */
`ifndef IEPU_CFG_SVH
`define IEPU_CFG_SVH

// Register byte addresses on the APB side
`define IEPU_OFF_MAIN_CTL    12'h000
`define IEPU_OFF_SECOND_CTL  12'h004
`define IEPU_OFF_THIRD_CTL   12'h008
`define IEPU_OFF_PERIPH_EN1  12'h00C
`define IEPU_OFF_PERIPH_EN2  12'h010
`define IEPU_OFF_PERIPH_PR1  12'h014
`define IEPU_OFF_PERIPH_PR2  12'h018
`define IEPU_OFF_PRIO_MODE   12'h01C
`define IEPU_OFF_TMR0_CTL    12'h020
`define IEPU_OFF_TMR0_COUNT  12'h024
`define IEPU_OFF_PORT_B      12'h028
`define IEPU_OFF_STATUS      12'h02C

// Main control fields
`define IEPU_MAIN_GIE        7
`define IEPU_MAIN_PERIPHERAL_IRQ_ENABLE       6
`define IEPU_MAIN_T0_EN      5
`define IEPU_MAIN_X0_EN      4
`define IEPU_MAIN_RB_EN      3
`define IEPU_MAIN_T0_FLAG    2
`define IEPU_MAIN_X0_FLAG    1
`define IEPU_MAIN_RB_FLAG    0

// Second control fields
`define IEPU_SEC_EDGE_LSB    4
`define IEPU_SEC_T0_PRIO     2
`define IEPU_SEC_RB_PRIO     0

// Third control fields
`define IEPU_THR_X2_PRIO     7
`define IEPU_THR_X1_PRIO     6
`define IEPU_THR_X2_EN       4
`define IEPU_THR_X1_EN       3
`define IEPU_THR_X2_FLAG     1
`define IEPU_THR_X1_FLAG     0

`define IEPU_PRIO_MODE_BIT   7
`define IEPU_T0_MODE16_BIT   0
`define IEPU_T0_RUN_BIT      1

// Reset values
`define IEPU_RST_EN2         4'h0
`define IEPU_RST_PR1         7'h7F
`define IEPU_RST_PR2         4'hF
`define IEPU_RST_EDGE        3'h7

// Timer0 rollover points
`define IEPU_T0_LOW_MAX      8'hFF
`define IEPU_T0_FULL_MAX     16'hFFFF

// Hardware return stack
`define IEPU_STACK_DEPTH     31
`define IEPU_PC_W            21

`endif

// ==== verilog/iepu_pkg.sv ====
/*
 * Types shared by the interrupt enable and priority unit.
 * Assumes iepu_cfg.svh is on the include path.
 */
`include "iepu_cfg.svh"

package iepu_pkg;

    // Fast return stack contents
    typedef struct packed {
        logic [7:0] working;
        logic [7:0] status;
        logic [7:0] bank;
    } iepu_ctx_s;

    typedef enum logic {
        IEPU_T0_8BIT  = 1'b0,
        IEPU_T0_16BIT = 1'b1
    } iepu_t0_mode_e;

    typedef logic [`IEPU_PC_W-1:0] iepu_pc_t;

endpackage : iepu_pkg

// ==== verilog/iepu_sync.sv ====
/*
 * Two flip-flop synchroniser bank for asynchronous pin levels.
 * Assumes pins are levels with no timing relation to clk.
 */
`timescale 1ns/1ns

module iepu_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_q
);

    logic [W-1:0] meta_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta_q[i]  <= 1'b0;
                level_q[i] <= 1'b0;
            end else begin
                meta_q[i]  <= pin_in[i];
                level_q[i] <= meta_q[i];
            end
        end
    end

endmodule : iepu_sync

// ==== verilog/iepu_ret_stack.sv ====
/*
 * Hardware return stack for program counter values.
 * Assumes push and pop are never high together; pushes when full are dropped.
 */
`timescale 1ns/1ns

module iepu_ret_stack
    import iepu_pkg::*;
(
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire logic     push,
    input  wire logic     pop,
    input  wire iepu_pc_t push_pc,
    output iepu_pc_t      top_q,
    output logic [4:0]    depth_q
);

    iepu_pc_t mem [`IEPU_STACK_DEPTH];
    logic [4:0] ptr_dec;
    logic [4:0] ptr_dec2;
    logic       full;

    assign ptr_dec  = depth_q - 5'h01;
    assign ptr_dec2 = depth_q - 5'h02;
    assign full     = (depth_q == 5'(`IEPU_STACK_DEPTH));

    always_ff @(posedge pclk) begin
        if (push && !full) begin
            mem[depth_q] <= push_pc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_q <= 5'h00;
            top_q   <= '0;
        end else if (push && !full) begin
            depth_q <= depth_q + 5'h01;
            top_q   <= push_pc;
        end else if (pop && depth_q != 5'h00) begin
            depth_q <= ptr_dec;
            // Top becomes the entry below the popped one
            top_q   <= (depth_q == 5'h01) ? '0 : mem[ptr_dec2];
        end
    end

endmodule : iepu_ret_stack

// ==== dv/iepu_core_model.sv ====
/*
 * Core sequencer stand-in: acknowledges each new interrupt request that rises while core_sleep is low.
 * Assumes the unit's request outputs are registered on pclk.
 */
`timescale 1ns/1ns

module iepu_core_model
    import iepu_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire logic      irq_high_q,
    input  wire logic      irq_low_q,
    input  wire logic      core_sleep,
    output logic           core_irq_ack,
    output iepu_pc_t       core_return_pc,
    output iepu_ctx_s      core_ctx
);
    logic req_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_prev_q     <= 1'b0;
            core_irq_ack   <= 1'b0;
            core_return_pc <= '0;
            core_ctx       <= '0;
        end else begin
            req_prev_q   <= irq_high_q | irq_low_q;
            core_irq_ack <= (irq_high_q | irq_low_q) & ~req_prev_q & ~core_sleep;
            if (core_irq_ack) begin
                core_return_pc <= core_return_pc + 21'h3;
                core_ctx       <= {core_ctx.bank, core_ctx.working + 8'h5, ~core_ctx.status};
            end
        end
    end
endmodule : iepu_core_model

// ==== dv/test_interrupt_enable_priority_unit.sv ====
/*
 * Self-checking bench for the interrupt enable and priority unit.
 * Assumes nothing of APB wait states; the master waits for pready.
 */
`timescale 1ns/1ns
`include "iepu_cfg.svh"

module test_interrupt_enable_priority_unit;
    import iepu_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, x0, x1, x2, sleep, pop;
    logic        pready, pslverr, err, irq_high_q, irq_low_q, wake_q, ack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [7:4]  pb;
    logic [6:0]  pf1;
    logic [3:0]  pf2;
    logic [4:0]  depth;
    iepu_pc_t    pc, top;
    iepu_pc_t    pcq[$];
    iepu_ctx_s   ctx, fctx, exp_ctx;
    int          n_fail, checks_done;
    integer      seed;
    logic [11:0] offs[3];
    logic [31:0] msk[3];

    iepu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq_zero(x0), .ext_irq_one(x1), .ext_irq_two(x2),
        .port_b_pins(pb), .periph_flags_one(pf1), .periph_flags_two(pf2),
        .core_sleep(sleep), .core_irq_ack(ack), .core_ret_pop(pop), .core_return_pc(pc),
        .core_ctx(ctx), .irq_high_q(irq_high_q), .irq_low_q(irq_low_q), .wake_q(wake_q),
        .fast_ctx_q(fctx), .stack_top_q(top), .stack_depth_q(depth));

    iepu_core_model i_core (.pclk(pclk), .presetn(presetn), .irq_high_q(irq_high_q),
        .irq_low_q(irq_low_q), .core_sleep(sleep), .core_irq_ack(ack),
        .core_return_pc(pc), .core_ctx(ctx));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Reference stack and saved context
    always @(posedge pclk) begin
        if (presetn === 1'b1 && ack === 1'b1) begin
            pcq.push_back(pc);
            exp_ctx = ctx;
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rd_chk

    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_n

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        give_verdict();
    end

    initial begin
        seed = 32'h2f3df7e6;
        {psel, penable, pwrite, x0, x1, x2, sleep, pop} = '0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pb = 4'h0;
        pf1 = 7'h0;
        pf2 = 4'h0;
        presetn = 1'b0;
        offs = '{`IEPU_OFF_PERIPH_EN2, `IEPU_OFF_PERIPH_PR1, `IEPU_OFF_PERIPH_PR2};
        msk = '{32'h0F, 32'h7F, 32'h0F};
        wait_n(8);
        presetn <= 1'b1;
        wait_n(4);
        rd_chk(`IEPU_OFF_PERIPH_EN2, 32'h0);
        rd_chk(`IEPU_OFF_PERIPH_PR1, 32'h7F);
        rd_chk(`IEPU_OFF_PERIPH_PR2, 32'h0F);
        for (int i = 0; i < 12; i++) begin
            v = $random(seed);
            wr(offs[i % 3], v);
            rd_chk(offs[i % 3], v & msk[i % 3]);
        end
        wr(`IEPU_OFF_PERIPH_EN2, 32'h0);
        wr(`IEPU_OFF_PERIPH_PR2, 32'h0F);
        bus(1'b0, 12'h0FC, 32'h0);
        chk(err, 1'b1);
        // Rising edge on pin zero, enabled, global on
        wr(`IEPU_OFF_MAIN_CTL, 32'h90);
        x0 <= 1'b1;
        wait_n(8);
        chk(irq_high_q, 1'b1);
        rd_chk(`IEPU_OFF_MAIN_CTL, 32'h92);
        wr(`IEPU_OFF_MAIN_CTL, 32'h80);
        x0 <= 1'b0;
        wait_n(8);
        rd_chk(`IEPU_OFF_MAIN_CTL, 32'h80);
        // Pin two set to falling edge
        wr(`IEPU_OFF_SECOND_CTL, 32'h35);
        wr(`IEPU_OFF_THIRD_CTL, 32'h90);
        x2 <= 1'b1;
        wait_n(8);
        rd_chk(`IEPU_OFF_THIRD_CTL, 32'h90);
        x2 <= 1'b0;
        wait_n(8);
        rd_chk(`IEPU_OFF_THIRD_CTL, 32'h92);
        chk(irq_high_q, 1'b1);
        wr(`IEPU_OFF_THIRD_CTL, 32'h0);
        // Wake from sleep with global enable off
        wr(`IEPU_OFF_MAIN_CTL, 32'h0);
        wr(`IEPU_OFF_THIRD_CTL, 32'h08);
        sleep <= 1'b1;
        x1 <= 1'b1;
        wait_n(8);
        chk(wake_q, 1'b1);
        chk(irq_high_q, 1'b0);
        wr(`IEPU_OFF_MAIN_CTL, 32'h80);
        wait_n(3);
        chk(irq_high_q, 1'b1);
        sleep <= 1'b0;
        x1 <= 1'b0;
        wr(`IEPU_OFF_THIRD_CTL, 32'h0);
        wr(`IEPU_OFF_MAIN_CTL, 32'h0);
        // Port change with every enable off
        bus(1'b0, `IEPU_OFF_PORT_B, 32'h0);
        pb <= ~pb;
        wait_n(8);
        rd_chk(`IEPU_OFF_MAIN_CTL, 32'h01);
        bus(1'b0, `IEPU_OFF_PORT_B, 32'h0);
        wr(`IEPU_OFF_MAIN_CTL, 32'h0);
        rd_chk(`IEPU_OFF_MAIN_CTL, 32'h0);
        // Timer0 rollovers
        wr(`IEPU_OFF_MAIN_CTL, 32'hA0);
        wr(`IEPU_OFF_TMR0_COUNT, 32'hFD);
        wr(`IEPU_OFF_TMR0_CTL, 32'h2);
        wait_n(8);
        chk(irq_high_q, 1'b1);
        rd_chk(`IEPU_OFF_MAIN_CTL, 32'hA4);
        wr(`IEPU_OFF_TMR0_CTL, 32'h0);
        wr(`IEPU_OFF_MAIN_CTL, 32'h0);
        wr(`IEPU_OFF_TMR0_COUNT, 32'hFD);
        wr(`IEPU_OFF_TMR0_CTL, 32'h3);
        wait_n(8);
        rd_chk(`IEPU_OFF_MAIN_CTL, 32'h0);
        wr(`IEPU_OFF_TMR0_CTL, 32'h0);
        wr(`IEPU_OFF_TMR0_COUNT, 32'hFFFD);
        wr(`IEPU_OFF_TMR0_CTL, 32'h3);
        wait_n(8);
        rd_chk(`IEPU_OFF_MAIN_CTL, 32'h04);
        wr(`IEPU_OFF_TMR0_CTL, 32'h0);
        wr(`IEPU_OFF_MAIN_CTL, 32'h0);
        // Peripheral group two source
        wr(`IEPU_OFF_PERIPH_EN2, 32'h1);
        pf2 <= 4'h1;
        wr(`IEPU_OFF_MAIN_CTL, 32'h80);
        wait_n(3);
        chk(irq_high_q, 1'b0);
        wr(`IEPU_OFF_MAIN_CTL, 32'hC0);
        wait_n(3);
        chk(irq_high_q, 1'b1);
        wr(`IEPU_OFF_PERIPH_PR2, 32'h0E);
        wait_n(3);
        chk(irq_high_q, 1'b1);
        wr(`IEPU_OFF_PRIO_MODE, 32'h80);
        wait_n(3);
        chk({irq_high_q, irq_low_q}, 2'b01);
        pf2 <= 4'h0;
        wr(`IEPU_OFF_MAIN_CTL, 32'h0);
        wait_n(4);
        chk(depth, pcq.size());
        chk(top, pcq[$]);
        chk(fctx, exp_ctx);
        pop <= 1'b1;
        @(posedge pclk);
        pop <= 1'b0;
        void'(pcq.pop_back());
        wait_n(2);
        chk(depth, pcq.size());
        chk(top, pcq[$]);
        give_verdict();
    end
endmodule : test_interrupt_enable_priority_unit
